// File: logic/sldc_buf_mem.sv
// receive frame buffer with registered read data
`timescale 1ns/1ps
module sldc_buf_mem (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic wr_en_in,
	input wire logic [sldc_pkg::BUF_AW-1:0] wr_addr_in,
	input wire logic [sldc_pkg::BUF_DW-1:0] wr_data_in,
	input wire logic rd_en_in,
	input wire logic [sldc_pkg::BUF_AW-1:0] rd_addr_in,
	output logic [sldc_pkg::BUF_DW-1:0] rd_data_out
);
	import sldc_pkg::*;

	logic [BUF_DW-1:0] mem [2**BUF_AW];

	always_ff @(posedge ref_clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_out <= '0;
		end else if (rd_en_in) begin
			rd_data_out <= mem[rd_addr_in];
		end
	end
endmodule

// File: logic/sldc_link_diag.sv
// serial port with receive/transmit diagnostic counters and link status
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Overview of operation
// RQ1 - with handshake on, characters start only while carrier detect is high, and a carrier drop mid-character counts a carrier loss.
// RQ2 - on the two-wire bus every transmitted character whose echo disagrees counts one collision.
// RQ3 - with handshake on, a missing clear-to-send reply within the wait after raising request-to-send counts a timeout.
// RQ4 - with handshake on, sending pauses between characters while clear-to-send is low and resumes the same frame.
// RQ5 - one frame has a bounded send time and overrunning it counts a transmission timeout.
// RQ6 - after a transmission timeout the rest of that frame is thrown away unsent.
// RQ7 - every received character with a bad parity bit counts a parity error.
// RQ8 - every character lost because the previous one was not yet taken counts an overrun.
// RQ9 - every received character with a low stop bit counts a framing error.
// RQ10 - writing 1 to link status clears every diagnostic counter.
// RQ11 - reading link status gives 1 while a protocol holds the port, else 0.
// RQ12 - each counter spans zero up to 2147483646.
// RQ13 - a received frame with any error is discarded, counted as discarded with its detail, and never delivered.
// RQ14 - every error-free received character is counted in either receive mode.
// RQ15 - counters saturate at their top value and stay there until cleared.
module sldc_link_diag #(
	parameter int unsigned CTS_WAIT_CYC = sldc_pkg::CTS_WAIT_CYC_DEF,
	parameter int unsigned TX_LIMIT_CYC = sldc_pkg::TX_LIMIT_CYC_DEF
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire sldc_pkg::sldc_bus_req_t bus_req_in,
	output logic [sldc_pkg::DATA_W-1:0] bus_rdata_out,
	output logic irq_out,
	input wire logic proto_in_use_in,
	input wire logic rxd_in,
	output logic txd_out,
	output logic txd_oe_n_out,
	output logic rts_out,
	input wire logic cts_in,
	input wire logic dcd_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_last_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	output logic [7:0] rx_data_out,
	output logic rx_last_out,
	output logic rx_valid_out,
	input wire logic rx_ready_in
);
	import sldc_pkg::*;

	localparam logic [CNT_W-1:0] CTS_END = CNT_W'(CTS_WAIT_CYC - 1);
	localparam logic [CNT_W-1:0] TX_END = CNT_W'(TX_LIMIT_CYC - 1);

	sldc_ctrl_t ctrl_ff;
	logic [15:0] div_ff;
	logic [NUM_CNT-1:0] ist_ff;
	logic [NUM_CNT-1:0] imask_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [CNT_W-1:0] cnt_ff [NUM_CNT];
	logic [NUM_CNT-1:0] ev;
	logic hs;
	logic two_wire;
	logic [15:0] div_m1;
	logic [15:0] div_half;
	logic cnt_clear;

	sldc_rx_st_t rx_st_ff;
	logic [15:0] rx_tmr_ff;
	logic [7:0] rx_sh_ff;
	logic [2:0] rx_bit_ff;
	logic rx_par_ff;
	logic rx_tick;
	logic rx_en;
	logic start_seen;
	logic cd_abort;
	logic char_done;
	logic err_par;
	logic err_frm;
	logic overrun_now;
	logic store;
	logic [BUF_AW:0] wptr_ff;
	logic frame_act_ff;
	logic frame_bad_ff;
	logic [23:0] gap_ff;
	logic [23:0] gap_lim;
	logic gap_end;
	logic commit;
	logic [BUF_AW:0] commit_len;

	logic out_busy_ff;
	logic rd_pend_ff;
	logic [BUF_AW:0] out_ptr_ff;
	logic [BUF_AW:0] out_len_ff;
	logic rd_issue;
	logic [BUF_DW-1:0] mem_q;
	logic [7:0] rx_data_ff;
	logic rx_last_ff;
	logic rx_valid_ff;

	sldc_tx_st_t tx_st_ff;
	logic [15:0] tx_tmr_ff;
	logic [7:0] tx_byte_ff;
	logic [2:0] tx_bit_ff;
	logic tx_last_ff;
	logic txd_ff;
	logic oe_n_ff;
	logic rts_ff;
	logic [CNT_W-1:0] ftmr_ff;
	logic [CNT_W-1:0] cts_tmr_ff;
	logic coll_seen_ff;
	logic tx_tick;
	logic tx_char;
	logic tx_framing;
	logic ok_send;
	logic ftmr_exp;
	logic cts_to_ev;
	logic coll_ev;
	logic tx_done_ev;

	assign hs = ctrl_ff.mode == MODE_232_HS;
	assign two_wire = ctrl_ff.mode == MODE_485_2W;
	assign div_m1 = div_ff - 16'h0001;
	assign div_half = {1'b0, div_ff[15:1]};
	assign cnt_clear = bus_req_in.wr && bus_req_in.addr == A_LINK &&
		bus_req_in.wdata == LINK_CLEAR;

	// register writes
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_ff <= CTRL_RST;
			div_ff <= DIV_RST;
			imask_ff <= '0;
		end else if (bus_req_in.wr) begin
			if (bus_req_in.addr == A_CTRL) begin
				ctrl_ff <= sldc_ctrl_t'(bus_req_in.wdata[CTRL_W-1:0]);
			end
			if (bus_req_in.addr == A_DIV) begin
				div_ff <= bus_req_in.wdata[15:0];
			end
			if (bus_req_in.addr == A_IMASK) begin
				imask_ff <= bus_req_in.wdata[NUM_CNT-1:0];
			end
		end
	end

	// sticky events, write one to clear, a new event wins
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ist_ff <= '0;
		end else if (bus_req_in.wr && bus_req_in.addr == A_ISTAT) begin
			ist_ff <= (ist_ff & ~bus_req_in.wdata[NUM_CNT-1:0]) | ev;
		end else begin
			ist_ff <= ist_ff | ev;
		end
	end
	assign irq_out = |(ist_ff & imask_ff);

	// diagnostic counters
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < NUM_CNT; i++) begin
				cnt_ff[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_CNT; i++) begin
				if (cnt_clear) begin
					cnt_ff[i] <= {{(CNT_W-1){1'b0}}, ev[i]}; // RQ10
				end else if (ev[i]) begin
					cnt_ff[i] <= sat_inc(cnt_ff[i]); // RQ12 RQ15
				end
			end
		end
	end

	// read data stands in the cycle after the strobe
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_ff <= '0;
		end else if (bus_req_in.rd) begin
			rdata_ff <= '0;
			if (bus_req_in.addr < A_LINK && bus_req_in.addr[1:0] == 2'h0) begin
				rdata_ff <= cnt_ff[bus_req_in.addr[5:2]];
			end
			unique case (bus_req_in.addr)
			A_LINK: rdata_ff <= {31'h00000000, proto_in_use_in}; // RQ11
			A_CTRL: rdata_ff <= {27'h0000000, ctrl_ff};
			A_DIV: rdata_ff <= {16'h0000, div_ff};
			A_ISTAT: rdata_ff <= {21'h000000, ist_ff};
			A_IMASK: rdata_ff <= {21'h000000, imask_ff};
			default: ;
			endcase
		end
	end
	assign bus_rdata_out = rdata_ff;

	// receiver
	assign rx_tick = rx_tmr_ff == 16'h0000;
	assign rx_en = !(two_wire && tx_framing);
	assign start_seen = rx_en && !rxd_in && (!hs || dcd_in); // RQ1
	assign cd_abort = hs && !dcd_in && rx_st_ff != R_IDLE; // RQ1
	assign char_done = rx_st_ff == R_STOP && rx_tick && !cd_abort;
	assign err_par = ctrl_ff.par_en &&
		rx_par_ff != par_bit(rx_sh_ff, ctrl_ff.par_odd);
	assign err_frm = !rxd_in;
	assign overrun_now = char_done && !err_par && !err_frm &&
		(out_busy_ff || (ctrl_ff.frame_mode && wptr_ff[BUF_AW])); // RQ8
	assign store = char_done && !err_par && !err_frm && !overrun_now;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_st_ff <= R_IDLE;
			rx_tmr_ff <= '0;
			rx_sh_ff <= '0;
			rx_bit_ff <= '0;
			rx_par_ff <= 1'b0;
		end else begin
			rx_tmr_ff <= rx_tick ? div_m1 : rx_tmr_ff - 16'h0001;
			unique case (rx_st_ff)
			R_IDLE: begin
				if (start_seen) begin
					rx_st_ff <= R_START;
					rx_tmr_ff <= div_half;
				end
			end
			R_START: begin
				if (cd_abort) begin
					rx_st_ff <= R_IDLE;
				end else if (rx_tick) begin
					rx_st_ff <= rxd_in ? R_IDLE : R_DATA;
					rx_bit_ff <= 3'h0;
				end
			end
			R_DATA: begin
				if (cd_abort) begin
					rx_st_ff <= R_IDLE;
				end else if (rx_tick) begin
					rx_sh_ff <= {rxd_in, rx_sh_ff[7:1]};
					rx_bit_ff <= rx_bit_ff + 3'h1;
					if (rx_bit_ff == 3'h7) begin
						rx_st_ff <= ctrl_ff.par_en ? R_PAR : R_STOP;
					end
				end
			end
			R_PAR: begin
				if (cd_abort) begin
					rx_st_ff <= R_IDLE;
				end else if (rx_tick) begin
					rx_par_ff <= rxd_in;
					rx_st_ff <= R_STOP;
				end
			end
			R_STOP: begin
				if (cd_abort || rx_tick) begin
					rx_st_ff <= R_IDLE;
				end
			end
			default: rx_st_ff <= R_IDLE;
			endcase
		end
	end

	// frame assembly; a frame ends after an idle gap
	assign gap_lim = 24'(div_ff) * 24'(FRAME_GAP_BITS);
	assign gap_end = ctrl_ff.frame_mode && frame_act_ff &&
		rx_st_ff == R_IDLE && gap_ff >= gap_lim;
	assign commit = ctrl_ff.frame_mode ?
		(gap_end && !frame_bad_ff && wptr_ff != '0) : store;
	assign commit_len = ctrl_ff.frame_mode ? wptr_ff : 7'h01;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wptr_ff <= '0;
			frame_act_ff <= 1'b0;
			frame_bad_ff <= 1'b0;
			gap_ff <= '0;
		end else if (gap_end || !ctrl_ff.frame_mode) begin
			wptr_ff <= '0;
			frame_act_ff <= 1'b0;
			frame_bad_ff <= 1'b0;
			gap_ff <= '0;
		end else begin
			gap_ff <= (rx_st_ff == R_IDLE) ? gap_ff + 24'h000001 : 24'h000000;
			if (char_done || cd_abort) begin
				frame_act_ff <= 1'b1;
			end
			if (store) begin
				wptr_ff <= wptr_ff + 7'h01;
			end
			if (cd_abort || (char_done && !store)) begin
				frame_bad_ff <= 1'b1; // RQ13
			end
		end
	end

	// delivery of a committed frame only
	assign rd_issue = out_busy_ff && !rd_pend_ff && !rx_valid_ff &&
		out_ptr_ff != out_len_ff;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_busy_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			out_ptr_ff <= '0;
			out_len_ff <= '0;
			rx_data_ff <= '0;
			rx_last_ff <= 1'b0;
			rx_valid_ff <= 1'b0;
		end else begin
			rd_pend_ff <= rd_issue;
			if (commit && !out_busy_ff) begin
				out_busy_ff <= 1'b1; // RQ13
				out_ptr_ff <= '0;
				out_len_ff <= commit_len;
			end
			if (rd_issue) begin
				out_ptr_ff <= out_ptr_ff + 7'h01;
			end
			if (rd_pend_ff) begin
				rx_data_ff <= mem_q;
				rx_last_ff <= out_ptr_ff == out_len_ff;
				rx_valid_ff <= 1'b1;
			end else if (rx_valid_ff && rx_ready_in) begin
				rx_valid_ff <= 1'b0;
				if (rx_last_ff) begin
					out_busy_ff <= 1'b0;
				end
			end
		end
	end
	assign rx_data_out = rx_data_ff;
	assign rx_last_out = rx_last_ff;
	assign rx_valid_out = rx_valid_ff;

	sldc_buf_mem u_buf (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.wr_en_in(store),
		.wr_addr_in(ctrl_ff.frame_mode ? wptr_ff[BUF_AW-1:0] : 6'h00),
		.wr_data_in(rx_sh_ff),
		.rd_en_in(rd_issue),
		.rd_addr_in(out_ptr_ff[BUF_AW-1:0]),
		.rd_data_out(mem_q)
	);

	// transmitter
	assign tx_tick = tx_tmr_ff == 16'h0000;
	assign tx_char = tx_st_ff == T_START || tx_st_ff == T_DATA ||
		tx_st_ff == T_PAR || tx_st_ff == T_STOP;
	assign tx_framing = tx_st_ff != T_IDLE && tx_st_ff != T_DROP;
	assign ok_send = !hs || cts_in; // RQ4
	assign ftmr_exp = tx_framing && ftmr_ff >= TX_END; // RQ5
	assign cts_to_ev = tx_st_ff == T_RTS && !cts_in &&
		cts_tmr_ff >= CTS_END && !ftmr_exp; // RQ3
	assign coll_ev = two_wire && tx_char && !coll_seen_ff &&
		tx_tmr_ff == div_half && rxd_in != txd_ff; // RQ2
	assign tx_done_ev = tx_st_ff == T_STOP && tx_tick && tx_last_ff &&
		!ftmr_exp;
	assign tx_ready_out = (tx_st_ff == T_NEXT && ok_send && !ftmr_exp) ||
		tx_st_ff == T_DROP; // RQ6

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_st_ff <= T_IDLE;
			tx_tmr_ff <= '0;
			tx_byte_ff <= '0;
			tx_bit_ff <= '0;
			tx_last_ff <= 1'b0;
			txd_ff <= 1'b1;
			ftmr_ff <= '0;
			cts_tmr_ff <= '0;
			coll_seen_ff <= 1'b0;
		end else begin
			tx_tmr_ff <= tx_tick ? div_m1 : tx_tmr_ff - 16'h0001;
			ftmr_ff <= tx_framing ? ftmr_ff + 32'h00000001 : 32'h00000000;
			if (coll_ev) begin
				coll_seen_ff <= 1'b1;
			end
			if (ftmr_exp) begin
				txd_ff <= 1'b1;
				tx_st_ff <= (tx_char && tx_last_ff) ? T_IDLE : T_DROP; // RQ6
			end else begin
				unique case (tx_st_ff)
				T_IDLE: begin
					if (tx_valid_in) begin
						tx_st_ff <= hs ? T_RTS : T_NEXT;
						cts_tmr_ff <= '0;
					end
				end
				T_RTS: begin
					cts_tmr_ff <= cts_tmr_ff + 32'h00000001;
					if (cts_in) begin
						tx_st_ff <= T_NEXT;
					end else if (cts_to_ev) begin
						tx_st_ff <= T_DROP;
					end
				end
				T_NEXT: begin
					if (ok_send && tx_valid_in) begin
						tx_byte_ff <= tx_data_in;
						tx_last_ff <= tx_last_in;
						txd_ff <= 1'b0;
						tx_tmr_ff <= div_m1;
						coll_seen_ff <= 1'b0;
						tx_st_ff <= T_START;
					end
				end
				T_START: begin
					if (tx_tick) begin
						txd_ff <= tx_byte_ff[0];
						tx_bit_ff <= 3'h0;
						tx_st_ff <= T_DATA;
					end
				end
				T_DATA: begin
					if (tx_tick && tx_bit_ff == 3'h7) begin
						txd_ff <= ctrl_ff.par_en ?
							par_bit(tx_byte_ff, ctrl_ff.par_odd) : 1'b1;
						tx_st_ff <= ctrl_ff.par_en ? T_PAR : T_STOP;
					end else if (tx_tick) begin
						txd_ff <= tx_byte_ff[tx_bit_ff + 3'h1];
						tx_bit_ff <= tx_bit_ff + 3'h1;
					end
				end
				T_PAR: begin
					if (tx_tick) begin
						txd_ff <= 1'b1;
						tx_st_ff <= T_STOP;
					end
				end
				T_STOP: begin
					if (tx_tick) begin
						tx_st_ff <= tx_last_ff ? T_IDLE : T_NEXT; // RQ4
					end
				end
				T_DROP: begin
					if (tx_valid_in && tx_last_in) begin
						tx_st_ff <= T_IDLE;
					end
				end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			oe_n_ff <= 1'b0;
			rts_ff <= 1'b0;
		end else begin
			// drive the bus from the first cycle of the start bit
			oe_n_ff <= two_wire && !tx_char &&
				!(tx_st_ff == T_NEXT && tx_ready_out && tx_valid_in);
			rts_ff <= hs && tx_framing;
		end
	end
	assign txd_out = txd_ff;
	assign txd_oe_n_out = oe_n_ff;
	assign rts_out = rts_ff;

	// event vector shared by counters and interrupt status
	always_comb begin
		ev = '0;
		ev[CI_CHR] = store; // RQ14
		ev[CI_FRX] = commit && ctrl_ff.frame_mode;
		ev[CI_FDIS] = gap_end && frame_bad_ff; // RQ13
		ev[CI_FTX] = tx_done_ev;
		ev[CI_CD] = cd_abort; // RQ1
		ev[CI_COLL] = coll_ev; // RQ2
		ev[CI_CTS] = cts_to_ev; // RQ3
		ev[CI_TTO] = ftmr_exp; // RQ5
		ev[CI_PAR] = char_done && err_par; // RQ7
		ev[CI_OVR] = overrun_now; // RQ8
		ev[CI_FRM] = char_done && err_frm; // RQ9
	end
endmodule

// File: logic/sldc_pkg.sv
// shared constants, types and helpers of the serial link diagnostic block
package sldc_pkg;
	localparam int CLK_KHZ = 100000;
	localparam int CTS_WAIT_MS = 10;
	localparam int TX_LIMIT_MS = 1000;
	localparam int CTS_WAIT_CYC_DEF = CTS_WAIT_MS * CLK_KHZ;
	localparam int TX_LIMIT_CYC_DEF = TX_LIMIT_MS * CLK_KHZ;
	localparam int FRAME_GAP_BITS = 35;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 32;
	localparam logic [CNT_W-1:0] CNT_MAX = 32'h7FFFFFFE;
	localparam int NUM_CNT = 11;
	localparam int CI_CHR = 0;
	localparam int CI_FRX = 1;
	localparam int CI_FDIS = 2;
	localparam int CI_FTX = 3;
	localparam int CI_CD = 4;
	localparam int CI_COLL = 5;
	localparam int CI_CTS = 6;
	localparam int CI_TTO = 7;
	localparam int CI_PAR = 8;
	localparam int CI_OVR = 9;
	localparam int CI_FRM = 10;

	localparam logic [ADDR_W-1:0] A_CNT_BASE = 8'h00;
	localparam logic [ADDR_W-1:0] A_LINK = 8'h2C;
	localparam logic [ADDR_W-1:0] A_CTRL = 8'h30;
	localparam logic [ADDR_W-1:0] A_DIV = 8'h34;
	localparam logic [ADDR_W-1:0] A_ISTAT = 8'h38;
	localparam logic [ADDR_W-1:0] A_IMASK = 8'h3C;
	localparam logic [DATA_W-1:0] LINK_CLEAR = 32'h00000001;

	localparam logic [1:0] MODE_485_2W = 2'h0;
	localparam logic [1:0] MODE_485_4W = 2'h1;
	localparam logic [1:0] MODE_232 = 2'h2;
	localparam logic [1:0] MODE_232_HS = 2'h3;

	localparam int CTRL_W = 5;
	typedef struct packed {
		logic frame_mode;
		logic par_odd;
		logic par_en;
		logic [1:0] mode;
	} sldc_ctrl_t;
	localparam sldc_ctrl_t CTRL_RST = 5'h02;
	localparam logic [15:0] DIV_RST = 16'h0364;

	localparam int BUF_AW = 6;
	localparam int BUF_DW = 8;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} sldc_bus_req_t;

	typedef enum logic [2:0] {
		R_IDLE = 3'h0,
		R_START = 3'h1,
		R_DATA = 3'h3,
		R_PAR = 3'h2,
		R_STOP = 3'h6
	} sldc_rx_st_t;

	typedef enum logic [2:0] {
		T_IDLE = 3'h0,
		T_RTS = 3'h1,
		T_NEXT = 3'h3,
		T_START = 3'h2,
		T_DATA = 3'h6,
		T_PAR = 3'h7,
		T_STOP = 3'h5,
		T_DROP = 3'h4
	} sldc_tx_st_t;

	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		sat_inc = (v >= CNT_MAX) ? CNT_MAX : v + 32'h00000001;
	endfunction

	function automatic logic par_bit(input logic [7:0] d, input logic odd);
		par_bit = (^d) ^ odd;
	endfunction
endpackage

// File: sim/sldc_link_diag_bench.sv
// self-checking bench for the serial diagnostic block
`timescale 1ns/1ps
module sldc_link_diag_bench;
	import sldc_pkg::*;
	typedef struct packed {
		logic [7:0] d;
		logic bp;
		logic bs;
		logic [3:0] idx;
	} sldc_row_t;
	logic ref_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	sldc_bus_req_t req = '0;
	logic [31:0] rdata;
	logic irq, txd, oe_n, rts, cts, dcd, rxd, rx_last, rx_valid, tx_ready;
	logic proto = 1'b0;
	logic tx_last = 1'b0;
	logic tx_valid = 1'b0;
	logic rx_ready = 1'b1;
	logic last_seen = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic [7:0] rx_seen = 8'h00;
	logic [7:0] rx_data;
	logic [31:0] exp_c [NUM_CNT];
	int bad_count = 0;
	int check_count = 0;
	int rx_n = 0;
	int g0;
	sldc_row_t rows [4] = '{'{8'h55, 1'b0, 1'b0, 4'(CI_CHR)},
		'{8'hA3, 1'b1, 1'b0, 4'(CI_PAR)}, '{8'h80, 1'b0, 1'b0, 4'(CI_CHR)},
		'{8'h0F, 1'b0, 1'b1, 4'(CI_FRM)}};
	always #5 ref_clk_in = ~ref_clk_in;
	sldc_link_diag #(.CTS_WAIT_CYC(200), .TX_LIMIT_CYC(2000)) uut (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus_req_in(req),
		.bus_rdata_out(rdata), .irq_out(irq), .proto_in_use_in(proto),
		.rxd_in(rxd), .txd_out(txd), .txd_oe_n_out(oe_n), .rts_out(rts),
		.cts_in(cts), .dcd_in(dcd), .tx_data_in(tx_data),
		.tx_last_in(tx_last), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
		.rx_data_out(rx_data), .rx_last_out(rx_last),
		.rx_valid_out(rx_valid), .rx_ready_in(rx_ready));
	sldc_remote_station rs (.ref_clk_in(ref_clk_in), .txd_in(txd),
		.txd_oe_n_in(oe_n), .rts_in(rts), .rxd_out(rxd), .cts_out(cts),
		.dcd_out(dcd));
	always @(posedge ref_clk_in) begin
		if (rx_valid && rx_ready) begin
			rx_seen <= rx_data;
			last_seen <= rx_last;
			rx_n <= rx_n + 1;
		end
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		cyc(1);
		req <= '0;
		cyc(1);
	endtask
	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		cyc(1);
		req <= '0;
		cyc(1);
		chk(n, e, rdata);
	endtask
	task automatic cnt_all;
		for (int i = 0; i < NUM_CNT; i++) begin
			rc($sformatf("counter %0d", i), 8'(4 * i), exp_c[i]);
		end
	endtask
	task automatic tx(input logic [7:0] d, input logic l);
		int k;
		tx_data <= d;
		tx_last <= l;
		tx_valid <= 1'b1;
		for (k = 0; k < 5000; k++) begin
			cyc(1);
			if (tx_ready === 1'b1) break;
		end
		if (k == 5000) begin
			$display("mismatch tx_ready expected 1 seen 0");
			bad_count++;
			finish_test();
		end else if (l) begin
			tx_valid <= 1'b0;
		end
	endtask
	task automatic rx(input logic [7:0] d, input logic bp);
		rs.send(d, 1'b1, bp, 1'b0, 1'b0);
	endtask
	initial begin
		foreach (exp_c[i]) exp_c[i] = 32'h0;
		cyc(2);
		rst_n_in <= 1'b1;
		cyc(1);
		rc("ctrl", A_CTRL, 32'h00000002);
		rc("divisor", A_DIV, 32'h00000364);
		rc("mask", A_IMASK, 32'h0);
		rc("unmapped", 8'h40, 32'h0);
		cnt_all();
		rc("link idle", A_LINK, 32'h0);
		proto <= 1'b1;
		rc("link busy", A_LINK, 32'h1);
		$display("test reset done");
		wr(A_DIV, 32'h4);
		wr(A_CTRL, 32'h6);
		wr(A_IMASK, 32'h100);
		for (int r = 0; r < 4; r++) begin
			rs.send(rows[r].d, 1'b1, rows[r].bp, rows[r].bs, 1'b0);
			cyc(80);
			exp_c[rows[r].idx]++;
			rc("rx count", 8'(4 * rows[r].idx), exp_c[rows[r].idx]);
			chk("irq", {31'h0, r > 0}, {31'h0, irq});
			if (rows[r].idx == CI_CHR)
				chk("rx byte", {24'h1, rows[r].d}, {23'h0, last_seen, rx_seen});
		end
		wr(A_IMASK, 32'h0);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(A_IMASK, 32'h100);
		wr(A_ISTAT, 32'h7FF);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(A_LINK, LINK_CLEAR);
		foreach (exp_c[i]) exp_c[i] = 32'h0;
		cnt_all();
		$display("test receive done");
		rx_ready <= 1'b0;
		rx(8'h11, 1'b0);
		rx(8'h22, 1'b0);
		cyc(20);
		rx_ready <= 1'b1;
		cyc(20);
		exp_c[CI_CHR]++;
		exp_c[CI_OVR]++;
		chk("kept byte", 32'h11, {24'h0, rx_seen});
		wr(A_CTRL, 32'h3);
		rs.send(8'h3C, 1'b0, 1'b0, 1'b0, 1'b1);
		cyc(40);
		exp_c[CI_CD]++;
		cnt_all();
		$display("test overrun carrier done");
		g0 = rs.got.size();
		fork
			begin
				tx(8'h5A, 1'b0);
				tx(8'hC3, 1'b0);
				tx(8'h81, 1'b1);
			end
			begin
				cyc(30);
				rs.cts_hold <= 1'b1;
				cyc(150);
				rs.cts_hold <= 1'b0;
			end
		join
		cyc(200);
		chk("tx count", 32'(g0 + 3), 32'(rs.got.size()));
		chk("tx first", 32'h5A, {24'h0, rs.got[g0]});
		chk("tx last", 32'h81, {24'h0, rs.got[g0 + 2]});
		exp_c[CI_FTX]++;
		g0 = rs.got.size();
		rs.cts_mute <= 1'b1;
		tx(8'hE7, 1'b0);
		tx(8'h18, 1'b1);
		cyc(50);
		rs.cts_mute <= 1'b0;
		chk("dropped", 32'(g0), 32'(rs.got.size()));
		exp_c[CI_CTS]++;
		cnt_all();
		$display("test cts done");
		fork
			begin
				tx(8'h96, 1'b0);
				tx(8'h69, 1'b0);
				tx(8'hF0, 1'b1);
			end
			begin
				cyc(20);
				rs.cts_hold <= 1'b1;
				cyc(2300);
				rs.cts_hold <= 1'b0;
			end
		join
		cyc(200);
		chk("sent before cut", 32'(g0 + 1), 32'(rs.got.size()));
		exp_c[CI_TTO]++;
		wr(A_CTRL, 32'h0);
		rs.echo <= 1'b1;
		rs.jam <= 1'b1;
		tx(8'hFF, 1'b1);
		cyc(60);
		rs.jam <= 1'b0;
		tx(8'hA5, 1'b1);
		cyc(60);
		rs.echo <= 1'b0;
		exp_c[CI_COLL]++;
		exp_c[CI_FTX] += 2;
		cnt_all();
		$display("test timeout collision done");
		wr(A_CTRL, 32'h16);
		g0 = rx_n;
		rx(8'h42, 1'b0);
		rx(8'h24, 1'b1);
		cyc(200);
		chk("no delivery", 32'(g0), 32'(rx_n));
		rx(8'h42, 1'b0);
		rx(8'h7E, 1'b0);
		cyc(200);
		chk("frame bytes", 32'(g0 + 2), 32'(rx_n));
		chk("frame end", 32'h17E, {23'h0, last_seen, rx_seen});
		exp_c[CI_CHR] += 3;
		exp_c[CI_PAR]++;
		exp_c[CI_FDIS]++;
		exp_c[CI_FRX]++;
		cnt_all();
		$display("test frame done");
		finish_test();
	end
endmodule

// File: sim/sldc_link_diag_checker.sv
// port-level checks of the serial diagnostic block
`timescale 1ns/1ps
module sldc_link_diag_checker #(
	parameter int unsigned CTS_WAIT_CYC = 200,
	parameter int unsigned TX_LIMIT_CYC = 2000
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire sldc_pkg::sldc_bus_req_t bus_req_in,
	input wire logic [sldc_pkg::DATA_W-1:0] bus_rdata_out,
	input wire logic proto_in_use_in,
	input wire logic txd_out,
	input wire logic txd_oe_n_out,
	input wire logic rts_out,
	input wire logic cts_in,
	input wire logic [7:0] rx_data_out,
	input wire logic rx_last_out,
	input wire logic rx_valid_out,
	input wire logic rx_ready_in
);
	import sldc_pkg::*;
	logic [31:0] rts_cnt_ff;
	logic [7:0] cts_low_ff;
	// cycles since clear-to-send was last seen high, saturating
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cts_low_ff <= 8'h00;
		end else if (cts_in) begin
			cts_low_ff <= 8'h00;
		end else if (cts_low_ff != 8'hFF) begin
			cts_low_ff <= cts_low_ff + 8'h01;
		end
	end
	// length of the current request-to-send period
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rts_cnt_ff <= 32'h0;
		end else begin
			rts_cnt_ff <= rts_out ? rts_cnt_ff + 32'h1 : 32'h0;
		end
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	link_read_a: assert property (
		bus_req_in.rd && bus_req_in.addr == A_LINK
		|=> bus_rdata_out == {31'h0, $past(proto_in_use_in)}
	) else $error("link status read wrong");
	clear_read_a: assert property (
		bus_req_in.wr && bus_req_in.addr == A_LINK
		&& bus_req_in.wdata == LINK_CLEAR
		##[1:2] bus_req_in.rd && bus_req_in.addr < A_LINK
		|=> bus_rdata_out <= 32'h1
	) else $error("counter not cleared");
	unmapped_a: assert property (
		bus_req_in.rd && bus_req_in.addr > A_IMASK |=> bus_rdata_out == 32'h0
	) else $error("unmapped read not zero");
	rdata_hold_a: assert property (
		!bus_req_in.rd |=> $stable(bus_rdata_out)
	) else $error("read data moved without read");
	cts_pause_a: assert property (
		rts_out && cts_low_ff >= 8'h40 |-> txd_out && $stable(txd_out)
	) else $error("line not idle while clear to send low");
	start_drive_a: assert property (
		$fell(txd_out) |-> !txd_oe_n_out
	) else $error("start bit sent undriven");
	rx_hold_a: assert property (
		rx_valid_out && !rx_ready_in |=> rx_valid_out
		&& $stable(rx_data_out) && $stable(rx_last_out)
	) else $error("receive byte dropped before taken");
	frame_len_a: assert property (
		rts_cnt_ff <= TX_LIMIT_CYC + 32'h190
	) else $error("frame ran past its time limit");
	cover property (rx_valid_out && !rx_ready_in);
	cover property (rx_valid_out && rx_ready_in && rx_last_out);
	cover property (rts_out && cts_low_ff >= 8'h40 ##1 cts_in);
endmodule
bind sldc_link_diag sldc_link_diag_checker #(
	.CTS_WAIT_CYC(CTS_WAIT_CYC), .TX_LIMIT_CYC(TX_LIMIT_CYC)) chk (
	.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus_req_in(bus_req_in),
	.bus_rdata_out(bus_rdata_out), .proto_in_use_in(proto_in_use_in),
	.txd_out(txd_out), .txd_oe_n_out(txd_oe_n_out), .rts_out(rts_out),
	.cts_in(cts_in), .rx_data_out(rx_data_out), .rx_last_out(rx_last_out),
	.rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in));

// File: sim/sldc_remote_station.sv
// remote serial station: receive line, handshake lines, txd decoder
`timescale 1ns/1ps
module sldc_remote_station (
	input wire logic ref_clk_in,
	input wire logic txd_in,
	input wire logic txd_oe_n_in,
	input wire logic rts_in,
	output logic rxd_out,
	output logic cts_out,
	output logic dcd_out
);
	int div = 4;
	int cts_lag = 3;
	int lag_cnt = 0;
	logic cts_mute = 1'b0;
	logic cts_hold = 1'b0;
	logic echo = 1'b0;
	logic jam = 1'b0;
	logic line_ff = 1'b1;
	logic dcd_ff = 1'b1;
	logic [7:0] b;
	logic [7:0] got[$];
	// shared bus idles high by bias when released; jammer pulls it low only while the block drives it
	assign rxd_out = echo ? (txd_oe_n_in | (txd_in & ~jam)) : line_ff;
	assign dcd_out = dcd_ff;
	initial cts_out = 1'b0;
	always @(posedge ref_clk_in) begin
		lag_cnt <= rts_in ? lag_cnt + 1 : 0;
		cts_out <= rts_in && lag_cnt >= cts_lag && !cts_mute && !cts_hold;
	end
	task automatic send(input logic [7:0] d, input logic pe, bp, bs, cdd);
		logic [10:0] f;
		f = {~bs, (^d) ^ bp, d, 1'b0};
		if (!pe) f[9] = ~bs;
		for (int i = 0; i < (pe ? 11 : 10); i++) begin
			line_ff <= f[i];
			if (cdd && i == 4) dcd_ff <= 1'b0;
			repeat (div) @(posedge ref_clk_in);
		end
		line_ff <= 1'b1;
		dcd_ff <= 1'b1;
		repeat (3 * div) @(posedge ref_clk_in);
	endtask
	// decode 8N1 characters on txd at mid-bit
	always begin
		@(negedge txd_in);
		repeat (div / 2) @(posedge ref_clk_in);
		for (int i = 0; i < 8; i++) begin
			repeat (div) @(posedge ref_clk_in);
			b[i] = txd_in;
		end
		repeat (div) @(posedge ref_clk_in);
		got.push_back(b);
	end
endmodule
